// >>> design/lss_consts.svh
// Constants of the lift supervision block: offsets, fields, resets and timing.
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH
`define LSS_CLK_MHZ 50
`define LSS_TICK_US 10000
`define LSS_TICK_CYC (`LSS_TICK_US * `LSS_CLK_MHZ)
`define LSS_TICK_W 19
`define LSS_TIME_W 12
`define LSS_IDX_CTRL 3'h0
`define LSS_IDX_CONT 3'h1
`define LSS_IDX_DSPD 3'h2
`define LSS_IDX_DTIM 3'h3
`define LSS_IDX_ENC 3'h4
`define LSS_IDX_REV 3'h5
`define LSS_IDX_TEMP 3'h6
`define LSS_IDX_STAT 3'h7
`define LSS_OFF_CTRL 8'h00
`define LSS_OFF_CONT 8'h04
`define LSS_OFF_DSPD 8'h08
`define LSS_OFF_DTIM 8'h0c
`define LSS_OFF_ENC 8'h10
`define LSS_OFF_REV 8'h14
`define LSS_OFF_TEMP 8'h18
`define LSS_OFF_STAT 8'h1c
`define LSS_CTRL_CONF_EN 0
`define LSS_CTRL_DOOR_EN 1
`define LSS_CTRL_ENCOUT_EN 2
`define LSS_CTRL_WARN_EN 3
`define LSS_CTRL_MODE 5:4
`define LSS_F_LO 11:0
`define LSS_F_HI 27:16
`define LSS_F_SPD 15:0
`define LSS_F_PCT 6:0
`define LSS_F_MARGIN 7:0
`define LSS_F_SINK 15:8
`define LSS_F_INT 23:16
`define LSS_F_JCT 31:24
`define LSS_MSK_CTRL 32'h0000003f
`define LSS_MSK_TIME 32'h0fff0fff
`define LSS_MSK_SPD 32'h0000ffff
`define LSS_MSK_PCT 32'h0fff007f
`define LSS_MSK_TEMP 32'hffffffff
`define LSS_RST_ZERO 32'h00000000
`define LSS_RST_DTIM 32'h000a0000
`define LSS_RST_TEMP 32'h5a5a5a05
`define LSS_ZERO_BAND 16'h000a
`define LSS_PCT_FULL 24'h000064
`define LSS_HYST_DEG 10'h003
`endif

// >>> design/lss_pkg.sv
// Types shared by the lift supervision modules.
package lss_pkg;
  typedef logic [11:0] lss_time_t;
  typedef enum logic [1:0] {
    LSS_DOOR_IDLE = 2'h0,
    LSS_DOOR_ARMED = 2'h1,
    LSS_DOOR_DELAY = 2'h3,
    LSS_DOOR_OPEN = 2'h2
  } lss_door_e;
  typedef enum logic [1:0] {
    LSS_ENC_FLAG = 2'h0,
    LSS_ENC_TRIP = 2'h1,
    LSS_ENC_WIDE = 2'h2,
    LSS_ENC_REV = 2'h3
  } lss_encmode_e;
endpackage : lss_pkg

// >>> design/lss_tmr_if.sv
// Interface between the supervisor and one tick timer.
`timescale 1ns/100ps
interface lss_tmr_if;
  logic tick;
  logic run;
  lss_pkg::lss_time_t limit;
  logic done;
  modport owner(output tick, run, limit, input done);
  modport timer(input tick, run, limit, output done);
endinterface : lss_tmr_if

// >>> design/lss_tick_tmr.sv
// Tick timer: counts control ticks while run holds, done once the limit is reached.
`timescale 1ns/100ps
module lss_tick_tmr (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Timer channel
  lss_tmr_if.timer tif
);
  lss_pkg::lss_time_t cnt_q;

  // Dropping run restarts the count, so every timed window starts from zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (!tif.run) begin
      cnt_q <= '0;
    end else if (tif.tick && (cnt_q < tif.limit)) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  assign tif.done = tif.run && (cnt_q >= tif.limit);
endmodule : lss_tick_tmr

// >>> design/lss_overheat.sv
// Overheat early warning with hysteresis over three temperature channels.
`timescale 1ns/100ps
`include "lss_consts.svh"
module lss_overheat (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Timebase and settings
  input wire logic tick_i,
  input wire logic [7:0] margin_i,
  input wire logic [2:0][7:0] trip_i,
  // Temperatures
  input wire logic [2:0][7:0] temp_i,
  // Warning
  output logic warn_o
);
  logic [2:0] hot;
  logic [2:0] cool;
  logic warn_q;

  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic signed [9:0] on_thr;
    logic signed [9:0] off_thr;
    logic signed [9:0] t_s;
    assign t_s = signed'({2'h0, temp_i[i]});
    assign on_thr = signed'({2'h0, trip_i[i]}) - signed'({2'h0, margin_i});
    assign off_thr = on_thr - signed'(`LSS_HYST_DEG);
    assign hot[i] = t_s > on_thr;
    assign cool[i] = t_s < off_thr;
  end

  // Any hot channel sets; only all channels cool clears; otherwise hold.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_q <= 1'b0;
    end else if (tick_i) begin
      if (|hot) begin
        warn_q <= 1'b1;
      end else if (&cool) begin
        warn_q <= 1'b0;
      end
    end
  end

  assign warn_o = warn_q;

  a_warn_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_i && (|hot) |=> warn_q)
    else $error("Warning not set by a hot channel.");
  a_warn_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    warn_q && !(tick_i && (&cool)) |=> warn_q)
    else $error("Warning cleared without all channels cool.");
endmodule : lss_overheat

// >>> design/lss_top.sv
// Lift supervision: contactor check, door-open timing, encoder faults, overheat warning.
//
// Behaviour
// - Trip when confirm input differs from command.
// - No mismatch trip inside check window.
// - Check window may outlast gate turn-on.
// - Trip at gate on if contactor open.
// - Door output has speed, delay, period settings.
// - Below start speed: delay, then hold period.
// - Arm only after speed exceeds start speed.
// - Same door logic in battery operation.
// - Zero start speed disables door output.
// - Encoder fault after domain dwell time.
// - No encoder checks under torque control.
// - Domains: reversal, overspeed, underspeed.
// - No broken-wire check at zero speed.
// - Mode 0 keeps running, alarm off.
// - Mode 0 drives encoder-fault output.
// - Modes 1-3 trip and raise alarm.
// - Warning margin below each trip temperature.
// - Warning on when any channel hot.
// - Warning off when all cool by three.
// - Startup delay from command to gate.
`timescale 1ns/100ps
`include "lss_consts.svh"
module lss_top #(
  parameter int TICK_CYCLES = `LSS_TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Drive state
  input wire logic contactor_command_out_i,
  input wire logic torque_ctrl_i,
  input wire logic signed [15:0] ref_speed_i,
  input wire logic signed [15:0] det_speed_i,
  input wire logic [7:0] heatsink_temp_i,
  input wire logic [7:0] internal_temp_i,
  input wire logic [7:0] junction_temp_i,
  // Contactor pin
  input wire logic contactor_confirm_in_i,
  // Sequence outputs
  output logic gate_on_o,
  output logic door_open_out_o,
  output logic encoder_fault_out_o,
  output logic overheat_warn_out_o,
  output logic alarm_out_o
);
  localparam int TW = 0;
  localparam int TS = 1;
  localparam int TD = 2;
  localparam int TP = 3;
  localparam int TE = 4;
  localparam int TR = 5;

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  // Word index of a byte address; 4'h8 marks an unmapped address.
  function automatic logic [3:0] reg_idx(input logic [7:0] a);
    return (a[7:5] == 3'h0 && a[1:0] == 2'h0) ? {1'b0, a[4:2]} : 4'h8;
  endfunction : reg_idx

  function automatic logic [31:0] cfg_mask(input logic [2:0] i);
    case (i)
      `LSS_IDX_CTRL: return `LSS_MSK_CTRL;
      `LSS_IDX_DSPD: return `LSS_MSK_SPD;
      `LSS_IDX_ENC, `LSS_IDX_REV: return `LSS_MSK_PCT;
      `LSS_IDX_TEMP: return `LSS_MSK_TEMP;
      default: return `LSS_MSK_TIME;
    endcase
  endfunction : cfg_mask

  function automatic logic [31:0] cfg_rst(input logic [2:0] i);
    case (i)
      `LSS_IDX_DTIM: return `LSS_RST_DTIM;
      `LSS_IDX_TEMP: return `LSS_RST_TEMP;
      default: return `LSS_RST_ZERO;
    endcase
  endfunction : cfg_rst

  logic [31:0] cfg_q [0:6];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [3:0] a_idx;
  logic wr_en;
  logic [31:0] stat_w;
  logic [`LSS_TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic cc_meta_q;
  logic cc_sync_q;
  logic cmd_prev_q;
  logic gate_q;
  logic ct_trip_q;
  logic sd_trip_q;
  logic alarm_q;
  logic door_q;
  logic encout_q;
  logic warn_q;
  logic warn_raw;
  logic gate_rise;
  logic mismatch;
  lss_pkg::lss_door_e door_st_q;
  lss_pkg::lss_encmode_e mode;
  logic [15:0] ra;
  logic [15:0] da;
  logic [23:0] ra_x100;
  logic [23:0] da_x100;
  logic [23:0] ra_xlvl;
  logic [23:0] da_xlvl;
  logic [23:0] ra_xrng;
  logic dom_q;
  logic rev_q;
  logic [15:0] door_spd;
  logic win_done;
  logic start_done;
  logic dly_done;
  logic per_done;
  logic enc_done;
  logic rev_done;

  lss_tmr_if tif [6] ();

  for (genvar i = 0; i < 6; i++) begin : g_tmr
    assign tif[i].tick = tick_q;
    lss_tick_tmr u_tmr (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .tif(tif[i])
    );
  end

  // APB slave: one wait state, the write lands on the completing edge.
  assign a_idx = reg_idx(paddr_i);
  assign wr_en = psel_i && penable_i && pready_q && pwrite_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (psel_i && penable_i && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= a_idx[3];
      prdata_q <= '0;
      if (!pwrite_i && !a_idx[3]) begin
        prdata_q <= (a_idx[2:0] == `LSS_IDX_STAT) ? stat_w : cfg_q[a_idx[2:0]];
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 7; i++) begin
        cfg_q[i] <= cfg_rst(3'(i));
      end
    end else if (wr_en && !a_idx[3] && a_idx[2:0] != `LSS_IDX_STAT) begin
      cfg_q[a_idx[2:0]] <= pwdata_i & cfg_mask(a_idx[2:0]);
    end
  end

  assign stat_w = {25'h0, gate_q, alarm_q, warn_q, door_q, enc_done, sd_trip_q, ct_trip_q};
  assign mode = lss_pkg::lss_encmode_e'(cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_MODE]);
  assign door_spd = cfg_q[`LSS_IDX_DSPD][`LSS_F_SPD];

  // Control timebase.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == `LSS_TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + `LSS_TICK_W'(1);
      tick_q <= 1'b0;
    end
  end

  // The confirmation pin is asynchronous to the core clock.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cc_meta_q <= 1'b0;
      cc_sync_q <= 1'b0;
    end else begin
      cc_meta_q <= contactor_confirm_in_i;
      cc_sync_q <= cc_meta_q;
    end
  end

  // Contactor supervision. The window restarts on every command change and is
  // independent of the gate, so a long window keeps running after gate on.
  assign tif[TW].run = (contactor_command_out_i == cmd_prev_q);
  assign tif[TW].limit = cfg_q[`LSS_IDX_CONT][`LSS_F_LO];
  assign win_done = tif[TW].done;
  assign tif[TS].run = contactor_command_out_i;
  assign tif[TS].limit = cfg_q[`LSS_IDX_CONT][`LSS_F_HI];
  assign start_done = tif[TS].done;
  assign gate_rise = contactor_command_out_i && start_done && !gate_q && !alarm_q;
  assign mismatch = cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_CONF_EN]
                    && (cc_sync_q != contactor_command_out_i) && win_done;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_prev_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      cmd_prev_q <= contactor_command_out_i;
      gate_q <= contactor_command_out_i && start_done && !alarm_q;
    end
  end

  // Trip flags hold until cleared by writing one to the status bit; a new
  // cause in the clearing cycle wins.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ct_trip_q <= 1'b0;
    end else begin
      ct_trip_q <= mismatch
                   || (gate_rise && cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_CONF_EN] && !cc_sync_q)
                   || (ct_trip_q && !(wr_en && a_idx == {1'b0, `LSS_IDX_STAT} && pwdata_i[0]));
    end
  end

  // Door-open sequence, judged once per tick on the magnitude of the final
  // reference, which covers battery operation as well.
  assign tif[TD].run = (door_st_q == lss_pkg::LSS_DOOR_DELAY);
  assign tif[TD].limit = cfg_q[`LSS_IDX_DTIM][`LSS_F_LO];
  assign dly_done = tif[TD].done;
  assign tif[TP].run = (door_st_q == lss_pkg::LSS_DOOR_OPEN);
  assign tif[TP].limit = cfg_q[`LSS_IDX_DTIM][`LSS_F_HI];
  assign per_done = tif[TP].done;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      door_st_q <= lss_pkg::LSS_DOOR_IDLE;
    end else if (!cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_DOOR_EN]) begin
      door_st_q <= lss_pkg::LSS_DOOR_IDLE;
    end else begin
      unique case (door_st_q)
        lss_pkg::LSS_DOOR_IDLE: begin
          if (tick_q && door_spd != 16'h0000 && ra > door_spd) begin
            door_st_q <= lss_pkg::LSS_DOOR_ARMED;
          end
        end
        lss_pkg::LSS_DOOR_ARMED: begin
          if (tick_q && ra < door_spd) begin
            door_st_q <= lss_pkg::LSS_DOOR_DELAY;
          end
        end
        lss_pkg::LSS_DOOR_DELAY: begin
          if (dly_done) begin
            door_st_q <= lss_pkg::LSS_DOOR_OPEN;
          end
        end
        lss_pkg::LSS_DOOR_OPEN: begin
          if (per_done) begin
            door_st_q <= lss_pkg::LSS_DOOR_IDLE;
          end
        end
      endcase
    end
  end

  // Encoder fault domains; products avoid a divider at the cost of width.
  assign ra = mag(ref_speed_i);
  assign da = mag(det_speed_i);
  assign ra_x100 = 24'(ra) * `LSS_PCT_FULL;
  assign da_x100 = 24'(da) * `LSS_PCT_FULL;
  assign ra_xlvl = 24'(ra) * 24'(cfg_q[`LSS_IDX_ENC][`LSS_F_PCT]);
  assign da_xlvl = 24'(da) * 24'(cfg_q[`LSS_IDX_ENC][`LSS_F_PCT]);
  assign ra_xrng = 24'(ra) * 24'(cfg_q[`LSS_IDX_REV][`LSS_F_PCT]);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dom_q <= 1'b0;
      rev_q <= 1'b0;
    end else if (tick_q) begin
      dom_q <= (ref_speed_i[15] != det_speed_i[15] && ra > `LSS_ZERO_BAND
                && da > `LSS_ZERO_BAND && da_x100 >= ra_xlvl)
               || (da_x100 > ra_x100 + ra_xlvl)
               || (ra > `LSS_ZERO_BAND && da <= `LSS_ZERO_BAND)
               || (mode != lss_pkg::LSS_ENC_FLAG && mode != lss_pkg::LSS_ENC_TRIP
                   && ra_x100 > da_x100 + da_xlvl);
      rev_q <= mode == lss_pkg::LSS_ENC_REV && ref_speed_i[15] != det_speed_i[15]
               && ra > `LSS_ZERO_BAND && da > `LSS_ZERO_BAND && da_x100 >= ra_xrng;
    end
  end

  assign tif[TE].run = dom_q && !torque_ctrl_i;
  assign tif[TE].limit = cfg_q[`LSS_IDX_ENC][`LSS_F_HI];
  assign enc_done = tif[TE].done;
  assign tif[TR].run = rev_q && !torque_ctrl_i;
  assign tif[TR].limit = cfg_q[`LSS_IDX_REV][`LSS_F_HI];
  assign rev_done = tif[TR].done;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sd_trip_q <= 1'b0;
    end else begin
      sd_trip_q <= (mode != lss_pkg::LSS_ENC_FLAG && (enc_done || rev_done))
                   || (sd_trip_q && !(wr_en && a_idx == {1'b0, `LSS_IDX_STAT} && pwdata_i[1]));
    end
  end

  lss_overheat u_oh (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_q),
    .margin_i(cfg_q[`LSS_IDX_TEMP][`LSS_F_MARGIN]),
    .trip_i({cfg_q[`LSS_IDX_TEMP][`LSS_F_JCT], cfg_q[`LSS_IDX_TEMP][`LSS_F_INT],
             cfg_q[`LSS_IDX_TEMP][`LSS_F_SINK]}),
    .temp_i({junction_temp_i, internal_temp_i, heatsink_temp_i}),
    .warn_o(warn_raw)
  );

  // Output stage.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_q <= 1'b0;
      door_q <= 1'b0;
      encout_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      alarm_q <= ct_trip_q || sd_trip_q;
      door_q <= door_st_q == lss_pkg::LSS_DOOR_OPEN;
      encout_q <= mode == lss_pkg::LSS_ENC_FLAG && enc_done
                  && cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_ENCOUT_EN];
      warn_q <= warn_raw && cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_WARN_EN];
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign gate_on_o = gate_q;
  assign door_open_out_o = door_q;
  assign encoder_fault_out_o = encout_q;
  assign overheat_warn_out_o = warn_q;
  assign alarm_out_o = alarm_q;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_mismatch_trip: assert property (mismatch |=> ct_trip_q ##1 alarm_q)
    else $error("Contactor mismatch did not trip.");
  a_window_grace: assert property (!ct_trip_q && !win_done && !gate_rise |=> !ct_trip_q)
    else $error("Trip inside the check window.");
  a_window_gate: assert property (gate_q && !win_done && !ct_trip_q |=> !ct_trip_q)
    else $error("Window ended at gate turn-on.");
  a_gate_open_trip: assert property (gate_rise && cfg_q[`LSS_IDX_CTRL][`LSS_CTRL_CONF_EN]
                                     && !cc_sync_q |=> ct_trip_q)
    else $error("Gate turned on with open contactor and no trip.");
  a_gate_delay: assert property ($rose(gate_q) |-> $past(start_done) && $past(contactor_command_out_i))
    else $error("Gate on before startup delay.");
  a_door_hold: assert property (door_st_q == lss_pkg::LSS_DOOR_OPEN && !per_done
                                |=> door_st_q == lss_pkg::LSS_DOOR_OPEN ##1 door_q)
    else $error("Door output not held for its period.");
  a_door_arm: assert property (door_st_q == lss_pkg::LSS_DOOR_IDLE && !tick_q
                               |=> door_st_q == lss_pkg::LSS_DOOR_IDLE)
    else $error("Door sequence armed without a tick.");
  a_door_zero: assert property (door_spd == 16'h0000 && door_st_q == lss_pkg::LSS_DOOR_IDLE
                                |=> door_st_q == lss_pkg::LSS_DOOR_IDLE [*2])
    else $error("Door sequence armed with zero start speed.");
  a_enc_torque: assert property (torque_ctrl_i |-> !enc_done && !rev_done)
    else $error("Encoder fault raised under torque control.");
  a_enc_mode0: assert property (mode == lss_pkg::LSS_ENC_FLAG && !sd_trip_q |=> !sd_trip_q)
    else $error("Mode 0 tripped on an encoder fault.");
  a_enc_trip: assert property (mode != lss_pkg::LSS_ENC_FLAG && enc_done
                               |=> sd_trip_q ##1 (alarm_q && !encoder_fault_out_o))
    else $error("Encoder fault did not trip with alarm.");
  a_apb_ready: assert property (psel_i && penable_i && !pready_q |=> pready_q ##1 !pready_q)
    else $error("APB answer not one cycle after access.");

  c_door_open: cover property ($rose(door_q));
  c_ct_trip: cover property ($rose(ct_trip_q));
  c_sd_trip: cover property ($rose(sd_trip_q));
  c_warn: cover property ($rose(warn_q));
endmodule : lss_top

// >>> verif/lss_contactor_model.sv
// Motor contactor model: the confirm pin follows the command after a mechanical lag.
`timescale 1ns/100ps
module lss_contactor_model #(
  parameter int LAG = 30
) (
  // Clock
  input wire logic clk_i,
  // Command and fault injection
  input wire logic cmd_i,
  input wire logic stuck_open_i,
  // Confirmation pin
  output logic confirm_o
);
  logic [LAG-1:0] lag_q = '0;
  always_ff @(posedge clk_i) begin
    lag_q <= {lag_q[LAG-2:0], cmd_i};
  end
  // A contact that never closes lets the bench provoke the gate-on trip on purpose.
  assign confirm_o = stuck_open_i ? 1'b0 : lag_q[LAG-1];
endmodule : lss_contactor_model

// >>> verif/tb_lift_supervision_signals.sv
// Self-checking bench for the lift supervision block.
`timescale 1ns/100ps
module tb_lift_supervision_signals;
  localparam int T = 20;
  typedef struct {logic [7:0] a; logic [31:0] v; logic e;} lss_reg_s;
  typedef struct {logic [7:0] c; logic signed [15:0] r; logic signed [15:0] d;
    logic q; logic f; logic al;} lss_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, gate, door, encf, warn, alarm, confirm;
  logic cmd = 1'b0, torque = 1'b0, stuck = 1'b0;
  logic signed [15:0] ref_spd = 16'sh0, det_spd = 16'sh0;
  logic [7:0] t_sink = 8'h14, t_int = 8'h14, t_jct = 8'h14;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int i, cnt;
  lss_reg_s regs [10] = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'h0, 1'b0},
    '{8'h08, 32'h0, 1'b0}, '{8'h0c, 32'h000a0000, 1'b0}, '{8'h10, 32'h0, 1'b0},
    '{8'h14, 32'h0, 1'b0}, '{8'h18, 32'h5a5a5a05, 1'b0}, '{8'h1c, 32'h0, 1'b0},
    '{8'h20, 32'h0, 1'b1}, '{8'h02, 32'h0, 1'b1}};
  // Mode, reference, detected, torque control, then fault output and alarm expected.
  lss_row_s rows [9] = '{'{8'h04, 16'sd500, -16'sd500, 1'b0, 1'b1, 1'b0},
    '{8'h14, 16'sd500, -16'sd500, 1'b0, 1'b0, 1'b1}, '{8'h14, 16'sd500, 16'sd200, 1'b0, 1'b0, 1'b0},
    '{8'h24, 16'sd500, 16'sd200, 1'b0, 1'b0, 1'b1}, '{8'h14, 16'sd500, -16'sd500, 1'b1, 1'b0, 1'b0},
    '{8'h14, 16'sd5, 16'sd0, 1'b0, 1'b0, 1'b0}, '{8'h14, 16'sd500, 16'sd0, 1'b0, 1'b0, 1'b1},
    '{8'h34, 16'sd500, -16'sd500, 1'b0, 1'b0, 1'b1}, '{8'h14, 16'sd500, 16'sd700, 1'b0, 1'b0, 1'b1}};

  always #10 clk = ~clk;

  lss_top #(.TICK_CYCLES(T)) lss_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .contactor_command_out_i(cmd), .torque_ctrl_i(torque), .ref_speed_i(ref_spd),
    .det_speed_i(det_spd), .heatsink_temp_i(t_sink), .internal_temp_i(t_int),
    .junction_temp_i(t_jct), .contactor_confirm_in_i(confirm), .gate_on_o(gate),
    .door_open_out_o(door), .encoder_fault_out_o(encf), .overheat_warn_out_o(warn),
    .alarm_out_o(alarm));

  // The lag must stay below the shortest startup delay, or gate-on would trip.
  lss_contactor_model #(.LAG(10)) lss_contactor_model_i (.clk_i(clk), .cmd_i(cmd),
    .stuck_open_i(stuck), .confirm_o(confirm));

  task results;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Holds the whole request until pready is seen at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task tk(input int n);
    repeat (n * T) @(posedge clk);
  endtask : tk

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    chk({27'h0, gate, door, encf, warn, alarm}, 32'h0);
    rst_n <= 1'b1;
    for (i = 0; i < 10; i++) begin
      apb(1'b0, regs[i].a, 32'h0);
      chk(rd, regs[i].v);
      chk({31'h0, er}, {31'h0, regs[i].e});
    end
    apb(1'b1, 8'h04, 32'hffffffff);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0fff0fff);
    // Contactor: confirm lags inside the check window, startup delay two ticks.
    apb(1'b1, 8'h04, 32'h00020003);
    apb(1'b1, 8'h00, 32'h1);
    cmd <= 1'b1;
    tk(1);
    chk({31'h0, gate}, 32'h0);
    tk(6);
    chk({30'h0, gate, alarm}, 32'h2);
    cmd <= 1'b0;
    tk(4);
    stuck <= 1'b1;
    cmd <= 1'b1;
    tk(6);
    chk({31'h0, alarm}, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd & 32'h1, 32'h1);
    cmd <= 1'b0;
    stuck <= 1'b0;
    tk(2);
    apb(1'b1, 8'h1c, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, alarm}, 32'h0);
    // Overheat warning with margin 5 below a trip of 90.
    apb(1'b1, 8'h00, 32'h8);
    t_sink <= 8'd86;
    tk(3);
    chk({31'h0, warn}, 32'h1);
    t_sink <= 8'd83;
    tk(3);
    chk({31'h0, warn}, 32'h1);
    t_sink <= 8'd81;
    tk(3);
    chk({31'h0, warn}, 32'h0);
    t_jct <= 8'd86;
    tk(3);
    chk({31'h0, warn}, 32'h1);
    t_jct <= 8'd20;
    // Door output: start speed 100, delay 2 ticks, period 3 ticks.
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h08, 32'd100);
    apb(1'b1, 8'h0c, 32'h00030002);
    ref_spd <= 16'sd50;
    tk(2);
    ref_spd <= 16'sd20;
    tk(8);
    chk({31'h0, door}, 32'h0);
    ref_spd <= 16'sd200;
    tk(2);
    ref_spd <= 16'sd50;
    tk(1);
    chk({31'h0, door}, 32'h0);
    cnt = 0;
    repeat (8 * T) begin
      @(posedge clk);
      cnt += int'(door);
    end
    chk({31'h0, cnt > 2 * T && cnt <= 3 * T + 1}, 32'h1);
    apb(1'b1, 8'h08, 32'd0);
    ref_spd <= 16'sd200;
    tk(2);
    ref_spd <= 16'sd50;
    tk(8);
    chk({31'h0, door}, 32'h0);
    // Encoder fault modes: level 10 percent, dwell 2 ticks, reversal check the same.
    apb(1'b1, 8'h10, 32'h0002000a);
    apb(1'b1, 8'h14, 32'h0002000a);
    for (i = 0; i < 9; i++) begin
      apb(1'b1, 8'h00, {24'h0, rows[i].c});
      ref_spd <= rows[i].r;
      det_spd <= rows[i].d;
      torque <= rows[i].q;
      tk(6);
      chk({30'h0, encf, alarm}, {30'h0, rows[i].f, rows[i].al});
      ref_spd <= 16'sh0;
      det_spd <= 16'sh0;
      torque <= 1'b0;
      tk(2);
      apb(1'b1, 8'h1c, 32'h3);
    end
    // Reset in mid-run: outputs drop at once and the settings reload.
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b1, 8'h18, 32'h01020304);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({26'h0, gate, door, encf, warn, alarm, pready}, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h5a5a5a05);
    results();
  end
endmodule : tb_lift_supervision_signals
